// ---- hw/asrp_defines.svh ----
// constants for the converter serial register port
`ifndef ASRP_DEFINES_SVH
`define ASRP_DEFINES_SVH
`define ASRP_CODE_W 24
`define ASRP_REG_W 24
`define ASRP_CFG_RST 24'h000117
`define ASRP_MODE_RST 24'h080060
`define ASRP_STAT_RST 24'h000080
`define ASRP_CFG_BURN 7
`define ASRP_CFG_REFDET 4
`define ASRP_CFG_UNIPOLAR 3
`define ASRP_STAT_RDYB 7
`define ASRP_STAT_MISSREF 5
`define ASRP_COMM_RD 6
`define ASRP_COMM_RS_HI 5
`define ASRP_COMM_RS_LO 3
`define ASRP_COMM_CREAD 2
`define ASRP_RS_STAT 3'h0
`define ASRP_RS_MODE 3'h1
`define ASRP_RS_CFG 3'h2
`define ASRP_RS_DATA 3'h3
`define ASRP_CREAD_ON 8'h5c
`define ASRP_CREAD_OFF 8'h58
`define ASRP_ONES_RESET 6'd40
`define ASRP_RESET_WAIT_US 200
`endif

// ---- hw/asrp_pkg.sv ----
// types for the converter serial register port
`default_nettype none
package asrp_pkg;
	typedef enum logic [1:0] {
		ST_COMM = 2'b00,
		ST_WRITE = 2'b01,
		ST_READ = 2'b10,
		ST_CREAD = 2'b11
	} asrp_state_e;
	typedef struct packed {
		logic [23:0] code;
		logic [2:0] chan;
	} asrp_result_s;
	typedef struct packed {
		logic burn_en;
		logic refdet_en;
		logic unipolar;
		logic [2:0] gain_sel;
	} asrp_cfg_s;
endpackage
`default_nettype wire

// ---- hw/asrp_port.sv ----
// serial register port and output data path of a multichannel converter
`timescale 1ns/10ps
`default_nettype none
`include "asrp_defines.svh"

module asrp_port (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// serial pins
	input wire logic cs_b,
	input wire logic sclk,
	input wire logic din,
	output logic dout_rdy_b,
	output logic dout_oe_b,
	// conversion side
	input wire asrp_pkg::asrp_result_s res_data,
	input wire logic res_valid,
	output logic res_ready,
	input wire logic ref_low,
	input wire logic ref_ok,
	// front end controls
	output logic burn_src_en,
	output logic burn_snk_en,
	output logic [2:0] gain_sel,
	output logic [2:0] chan_sel,
	output logic port_reset
);

	// ********************
	// pin synchronisers
	// ********************
	logic [1:0] cs_sync_q, sclk_sync_q, din_sync_q;
	logic sclk_prev_q;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cs_sync_q <= 2'h3;
			sclk_sync_q <= 2'h3;
			din_sync_q <= 2'h0;
			sclk_prev_q <= 1'b1;
		end else begin
			cs_sync_q <= {cs_sync_q[0], cs_b};
			sclk_sync_q <= {sclk_sync_q[0], sclk};
			din_sync_q <= {din_sync_q[0], din};
			sclk_prev_q <= sclk_sync_q[1];
		end
	end
	logic cs_act, sclk_rise, sclk_fall, din_s;
	assign cs_act = ~cs_sync_q[1];
	assign sclk_rise = cs_act & sclk_sync_q[1] & ~sclk_prev_q;
	assign sclk_fall = cs_act & ~sclk_sync_q[1] & sclk_prev_q;
	assign din_s = din_sync_q[1];

	// last eight din bits, so the exit byte is seen while results stream out
	logic [6:0] din_hist_q;
	logic [7:0] cmd_hist;
	assign cmd_hist = {din_hist_q, din_s};
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			din_hist_q <= 7'h00;
		end else if (sclk_rise) begin
			din_hist_q <= cmd_hist[6:0];
		end
	end

	// ********************
	// forty ones detector
	// ********************
	logic [5:0] ones_q;
	logic soft_rst;
	assign soft_rst = sclk_rise & din_s & (ones_q == `ASRP_ONES_RESET - 6'd1);
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ones_q <= 6'h00;
		end else if (sclk_rise) begin
			if (!din_s || soft_rst) begin
				ones_q <= 6'h00;
			end else begin
				ones_q <= ones_q + 6'h01;
			end
		end
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			port_reset <= 1'b1;
		end else begin
			port_reset <= soft_rst;
		end
	end

	// ********************
	// two entry result buffer
	// ********************
	asrp_pkg::asrp_result_s buf_q [2];
	logic wp_q, rp_q;
	logic [1:0] cnt_q;
	logic buf_pop, buf_valid, upd_ok;
	assign res_ready = (cnt_q != 2'h2);
	assign buf_valid = (cnt_q != 2'h0);
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
		end else if (soft_rst) begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (res_valid && res_ready) begin
				wp_q <= ~wp_q;
			end
			if (buf_pop) begin
				rp_q <= ~rp_q;
			end
			cnt_q <= cnt_q + {1'b0, res_valid & res_ready} - {1'b0, buf_pop};
		end
	end
	always_ff @(posedge sys_clk) begin
		if (res_valid && res_ready) begin
			buf_q[wp_q] <= res_data;
		end
	end

	// ********************
	// registers
	// ********************
	logic [23:0] cfg_q, mode_q, data_q;
	logic [7:0] stat_word;
	logic [2:0] stat_chan_q;
	logic missref_q, rdy_b_q, data_busy;
	asrp_pkg::asrp_state_e st_q;
	logic [23:0] sh_q;
	logic [4:0] bit_q;
	logic [2:0] rs_q;
	logic cread_q;
	logic [23:0] code_fmt;
	asrp_pkg::asrp_cfg_s cfg;
	assign cfg = '{burn_en: cfg_q[`ASRP_CFG_BURN], refdet_en: cfg_q[`ASRP_CFG_REFDET],
		unipolar: cfg_q[`ASRP_CFG_UNIPOLAR], gain_sel: cfg_q[2:0]};
	assign gain_sel = cfg.gain_sel;
	assign chan_sel = cfg_q[18:16];
	assign burn_src_en = cfg.burn_en;
	assign burn_snk_en = cfg.burn_en;

	// the modulator hands over twos complement; unipolar results are already straight
	always_comb begin
		if (missref_q) begin
			code_fmt = 24'hffffff;
		end else if (cfg.unipolar) begin
			code_fmt = buf_q[rp_q].code;
		end else begin
			code_fmt = {~buf_q[rp_q].code[23], buf_q[rp_q].code[22:0]};
		end
	end

	// missing reference flag with hysteresis thresholds
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			missref_q <= 1'b0;
		end else if (soft_rst || !cfg.refdet_en) begin
			missref_q <= 1'b0;
		end else if (ref_low) begin
			missref_q <= 1'b1;
		end else if (ref_ok) begin
			missref_q <= 1'b0;
		end
	end

	// result update waits until no data read is shifting
	assign data_busy = (st_q == asrp_pkg::ST_READ && rs_q == `ASRP_RS_DATA)
		|| (st_q == asrp_pkg::ST_CREAD && bit_q != 5'h0);
	// a result is only taken once ready stands high; an unread result in the data register is overwritten
	assign upd_ok = buf_valid & ~data_busy;
	assign buf_pop = upd_ok & rdy_b_q;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			data_q <= 24'h000000;
			stat_chan_q <= 3'h0;
		end else if (soft_rst) begin
			data_q <= 24'h000000;
			stat_chan_q <= 3'h0;
		end else if (buf_pop) begin
			data_q <= code_fmt;
			stat_chan_q <= buf_q[rp_q].chan;
		end
	end

	// ********************
	// serial state machine
	// ********************
	logic data_read_done, cmd_done;
	logic [7:0] cmd_byte;
	assign cmd_byte = {sh_q[6:0], din_s};
	assign cmd_done = sclk_rise && st_q == asrp_pkg::ST_COMM && bit_q == 5'd7;
	assign data_read_done = sclk_rise && bit_q == 5'd23
		&& ((st_q == asrp_pkg::ST_READ && rs_q == `ASRP_RS_DATA) || st_q == asrp_pkg::ST_CREAD);

	// ready goes high one cycle before the data register changes, low on the same edge as the change
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdy_b_q <= 1'b1;
		end else if (soft_rst) begin
			rdy_b_q <= 1'b1;
		end else if (upd_ok && !rdy_b_q) begin
			rdy_b_q <= 1'b1;
		end else if (data_read_done) begin
			rdy_b_q <= 1'b1;
		end else if (buf_pop) begin
			rdy_b_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= asrp_pkg::ST_COMM;
			bit_q <= 5'h0;
			rs_q <= 3'h0;
			cread_q <= 1'b0;
			sh_q <= 24'h000000;
			cfg_q <= `ASRP_CFG_RST;
			mode_q <= `ASRP_MODE_RST;
		end else if (soft_rst) begin
			st_q <= asrp_pkg::ST_COMM;
			bit_q <= 5'h0;
			rs_q <= 3'h0;
			cread_q <= 1'b0;
			sh_q <= 24'h000000;
			cfg_q <= `ASRP_CFG_RST;
			mode_q <= `ASRP_MODE_RST;
		end else if (!cs_act) begin
			bit_q <= 5'h0;
			if (st_q != asrp_pkg::ST_CREAD) begin
				st_q <= cread_q ? asrp_pkg::ST_CREAD : asrp_pkg::ST_COMM;
			end
		end else begin
			case (st_q)
				asrp_pkg::ST_COMM: begin
					if (sclk_rise) begin
						sh_q <= {sh_q[22:0], din_s};
						bit_q <= bit_q + 5'h1;
						if (cmd_done) begin
							bit_q <= 5'h0;
							rs_q <= cmd_byte[`ASRP_COMM_RS_HI:`ASRP_COMM_RS_LO];
							if (cmd_byte == `ASRP_CREAD_ON) begin
								cread_q <= 1'b1;
								st_q <= asrp_pkg::ST_CREAD;
							end else if (cmd_byte[`ASRP_COMM_RD]) begin
								st_q <= asrp_pkg::ST_READ;
								case (cmd_byte[`ASRP_COMM_RS_HI:`ASRP_COMM_RS_LO])
									`ASRP_RS_STAT: sh_q <= {stat_word, 16'h0000};
									`ASRP_RS_MODE: sh_q <= mode_q;
									`ASRP_RS_CFG: sh_q <= cfg_q;
									`ASRP_RS_DATA: sh_q <= data_q;
									default: sh_q <= 24'h000000;
								endcase
							end else begin
								st_q <= asrp_pkg::ST_WRITE;
							end
						end
					end
				end
				asrp_pkg::ST_WRITE: begin
					if (sclk_rise) begin
						sh_q <= {sh_q[22:0], din_s};
						bit_q <= bit_q + 5'h1;
						if (bit_q == 5'd23) begin
							bit_q <= 5'h0;
							st_q <= asrp_pkg::ST_COMM;
							case (rs_q)
								`ASRP_RS_MODE: mode_q <= {sh_q[22:0], din_s};
								`ASRP_RS_CFG: cfg_q <= {sh_q[22:0], din_s};
								default: ;
							endcase
						end
					end
				end
				asrp_pkg::ST_READ: begin
					if (sclk_rise) begin
						bit_q <= bit_q + 5'h1;
						if ((rs_q == `ASRP_RS_STAT && bit_q == 5'd7) || bit_q == 5'd23) begin
							bit_q <= 5'h0;
							st_q <= asrp_pkg::ST_COMM;
						end
					end else if (sclk_fall && bit_q != 5'h0) begin
						sh_q <= {sh_q[22:0], 1'b0};
					end
				end
				asrp_pkg::ST_CREAD: begin
					// din watched for the exit pattern while results stream out
					if (bit_q == 5'h0 && !sclk_rise) begin
						sh_q <= data_q;
					end
					if (sclk_rise && !rdy_b_q) begin
						bit_q <= bit_q + 5'h1;
						if (bit_q == 5'd7 && cmd_hist == `ASRP_CREAD_OFF) begin
							bit_q <= 5'h0;
							cread_q <= 1'b0;
							st_q <= asrp_pkg::ST_COMM;
						end else if (bit_q == 5'd23) begin
							bit_q <= 5'h0;
						end
					end else if (sclk_fall && bit_q != 5'h0) begin
						sh_q <= {sh_q[22:0], 1'b0};
					end
				end
				default: st_q <= asrp_pkg::ST_COMM;
			endcase
		end
	end

	assign stat_word = {rdy_b_q, 1'b0, missref_q, 2'h0, stat_chan_q};

	// ********************
	// output pin
	// ********************
	logic is_out;
	assign is_out = (st_q == asrp_pkg::ST_READ)
		|| (st_q == asrp_pkg::ST_CREAD && !rdy_b_q && cs_act);
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dout_rdy_b <= 1'b1;
			dout_oe_b <= 1'b1;
		end else begin
			dout_oe_b <= ~cs_act;
			dout_rdy_b <= is_out ? sh_q[23] : rdy_b_q;
		end
	end

endmodule
`default_nettype wire

// ---- tb/asrp_port_asserts.sv ----
// pin-level assertions for the converter serial register port
`timescale 1ns/10ps
`default_nettype none
module asrp_port_asserts (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// serial pins
	input wire logic cs_b,
	input wire logic dout_rdy_b,
	input wire logic dout_oe_b,
	// result and front end
	input wire logic res_valid,
	input wire logic res_ready,
	input wire logic burn_src_en,
	input wire logic burn_snk_en,
	input wire logic [2:0] gain_sel,
	input wire logic [2:0] chan_sel,
	input wire logic port_reset
);
	// ****
	// checks
	// ****
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_burn_pair: assert property (burn_src_en == burn_snk_en)
		else $error("burnout enables differ");
	a_oe_idle: assert property (cs_b[*4] |-> dout_oe_b)
		else $error("dout driven while deselected");
	a_oe_drive: assert property ((!cs_b)[*4] |-> !dout_oe_b)
		else $error("dout not driven while selected");
	a_rst_quiet: assert property ($rose(rst_b) |-> dout_rdy_b && dout_oe_b)
		else $error("pins not idle after reset");
	a_reset_pulse: assert property (port_reset |=> !port_reset)
		else $error("port reset longer than a cycle");
	a_reset_regs: assert property (port_reset |=> {burn_src_en, chan_sel, gain_sel} == 7'h07)
		else $error("controls not back to reset values");
	a_cfg_quiet: assert property ((cs_b && !port_reset)[*8] |-> $stable({gain_sel, chan_sel}))
		else $error("controls changed while deselected");
	a_ready_new: assert property (res_valid && res_ready && cs_b && dout_rdy_b |-> ##[1:16] !dout_rdy_b)
		else $error("ready not signalled for new result");
	c_soft_reset: cover property ($rose(port_reset));
	c_ready_idle: cover property (cs_b && $fell(dout_rdy_b));
	c_buf_stall: cover property (res_valid && !res_ready);
endmodule
bind asrp_port asrp_port_asserts chk (.sys_clk, .rst_b, .cs_b, .dout_rdy_b, .dout_oe_b,
	.res_valid, .res_ready, .burn_src_en, .burn_snk_en, .gain_sel, .chan_sel, .port_reset);
`default_nettype wire

// ---- tb/asrp_host.sv ----
// host serial port model for the converter register port
`timescale 1ns/10ps
`default_nettype none
module asrp_host (
	// serial pins
	output logic cs_b,
	output logic sclk,
	output logic din,
	input wire logic dout
);
	// ****
	// frames
	// ****
	initial begin
		cs_b = 1'b1;
		sclk = 1'b1;
		din = 1'b0;
	end
	// n bits msb first; read bits taken mid high phase, clear of both output updates
	task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
		rx = '0;
		#3.3;
		cs_b = 1'b0;
		#16;
		for (int i = n - 1; i >= 0; i--) begin
			sclk = 1'b0;
			din = tx[i];
			#16;
			sclk = 1'b1;
			#8;
			rx[i] = dout;
			#8;
		end
		#16;
		din = 1'b0;
		cs_b = 1'b1;
		#16;
	endtask
	// clock runs with data high while deselected
	task automatic spin(input int n);
		din = 1'b1;
		repeat (n) begin
			sclk = 1'b0;
			#16;
			sclk = 1'b1;
			#16;
		end
		din = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- tb/asrp_port_tb.sv ----
// self-checking bench for the converter serial register port
`timescale 1ns/10ps
`default_nettype none
module asrp_port_tb;
	logic sys_clk, rst_b, cs_b, sclk, din, dout_rdy_b, dout_oe_b, dout_w, flip;
	logic res_valid, res_ready, ref_low, ref_ok, burn_src_en, burn_snk_en, port_reset;
	logic [2:0] gain_sel, chan_sel;
	asrp_pkg::asrp_result_s res_data;
	logic [39:0] v;
	logic [23:0] rnd, cfg;
	logic [23:0] codes[5];
	logic [23:0] exp_q[$];
	int err_count, n_tests;
	// ****
	// clock, released line, instances
	// ****
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) flip <= ~flip;
	assign dout_w = dout_oe_b ? flip : dout_rdy_b;
	asrp_port uut (.sys_clk, .rst_b, .cs_b, .sclk, .din, .dout_rdy_b, .dout_oe_b, .res_data,
		.res_valid, .res_ready, .ref_low, .ref_ok, .burn_src_en, .burn_snk_en, .gain_sel,
		.chan_sel, .port_reset);
	asrp_host host (.cs_b, .sclk, .din, .dout(dout_w));
	function automatic logic [23:0] lfsr(input logic [23:0] s);
		return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
	endfunction
	function automatic logic [23:0] coded(input logic [23:0] c);
		if (ref_low)
			return 24'hffffff;
		return cfg[3] ? c : {~c[23], c[22:0]};
	endfunction
	task automatic tick;
		@(posedge sys_clk) #1;
	endtask
	task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] s);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic rd(input logic [7:0] cm, input int n);
		host.xfer(40'(cm) << n, n + 8, v);
		v = v & ((40'h1 << n) - 40'h1);
	endtask
	task automatic push(input logic [23:0] c);
		tick();
		res_data = {c, 3'h1};
		res_valid = 1'b1;
		for (int k = 0; k < 64 && res_ready !== 1'b1; k++) tick();
		@(posedge sys_clk) #1 res_valid = 1'b0;
		exp_q.push_back(coded(c));
	endtask
	task automatic wait_rdy;
		for (int k = 0; k < 200 && dout_rdy_b !== 1'b0; k++) tick();
		chk("ready low", 40'h0, {39'h0, dout_rdy_b});
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ****
	// tests
	// ****
	initial begin
		#400us;
		err_count++;
		final_report();
	end
	initial begin
		sys_clk = 1'b0;
		flip = 1'b0;
		rst_b = 1'b0;
		res_valid = 1'b0;
		res_data = '0;
		ref_low = 1'b0;
		ref_ok = 1'b1;
		err_count = 0;
		n_tests = 0;
		rnd = 24'h000040;
		cfg = 24'h000117;
		codes = '{24'h000000, 24'h800000, 24'h7fffff, 24'hffffff, 24'h000000};
		repeat (3) @(posedge sys_clk);
		#1 rst_b = 1'b1;
		repeat (3) tick();
		chk("oe idle", 40'h1, {39'h0, dout_oe_b});
		rd(8'h50, 24);
		chk("config", 40'h000117, v);
		rd(8'h48, 24);
		chk("mode", 40'h080060, v);
		rd(8'h40, 8);
		chk("status", 40'h80, v);
		$display("reset test done");
		for (int u = 1; u >= 0; u--) begin
			cfg = u ? 24'h05009b : 24'h050093;
			host.xfer({8'h00, 8'h10, cfg}, 32, v);
			chk("chan gain", 40'h2b, {34'h0, chan_sel, gain_sel});
			chk("burnout", 40'h3, {38'h0, burn_src_en, burn_snk_en});
			rnd = lfsr(rnd);
			codes[4] = rnd;
			foreach (codes[i]) begin
				push(codes[i]);
				wait_rdy();
				repeat (2) begin
					rd(8'h58, 24);
					chk("data", 40'(exp_q[$]), v);
				end
				chk("ready high", 40'h1, {39'h0, dout_rdy_b});
			end
		end
		$display("coding test done");
		tick();
		ref_low = 1'b1;
		ref_ok = 1'b0;
		push(lfsr(rnd));
		wait_rdy();
		rd(8'h58, 24);
		chk("clamp", 40'(exp_q[$]), v);
		rd(8'h40, 8);
		chk("missing ref", 40'h20, v & 40'h20);
		tick();
		ref_low = 1'b0;
		ref_ok = 1'b1;
		$display("reference test done");
		host.xfer(40'h5c, 8, v);
		repeat (2) begin
			rnd = lfsr(rnd);
			push(rnd);
			wait_rdy();
			host.xfer(40'h0, 24, v);
			chk("stream", 40'(exp_q.pop_back()), v);
			chk("ready high", 40'h1, {39'h0, dout_rdy_b});
		end
		push(lfsr(rnd));
		wait_rdy();
		host.xfer(40'h58, 8, v);
		rd(8'h50, 24);
		chk("leave stream", 40'(cfg), v);
		$display("stream test done");
		repeat (4) begin
			rnd = lfsr(rnd);
			push(rnd);
		end
		repeat (20) tick();
		wait_rdy();
		rd(8'h58, 24);
		chk("latest", 40'(exp_q[$]), v);
		host.spin(48);
		chk("ignored", 40'h2b, {34'h0, chan_sel, gain_sel});
		$display("buffer and select test done");
		host.xfer(40'hffffffffff, 40, v);
		#200us;
		chk("soft reset", 40'h7, {37'h0, gain_sel});
		rd(8'h50, 24);
		chk("config", 40'h000117, v);
		$display("soft reset test done");
		final_report();
	end
endmodule
`default_nettype wire
